// >>> inc/spd_pkg.sv
// Shared types and constants of the servo panel status display
package spd_pkg;

    // Clock and message hold time
    localparam int          SPD_CLK_PERIOD_NS = 8;
    localparam int          SPD_MSG_TIME_MS   = 1000;
    localparam int          SPD_MSG_CYCLES    = SPD_MSG_TIME_MS * 1000000 / SPD_CLK_PERIOD_NS;

    // Converter geometry
    localparam int          SPD_BIN_W         = 32;
    localparam int          SPD_BCD_DIGITS    = 10;
    localparam logic [5:0]  SPD_CONV_STEPS    = 6'h20;

    // Segment bit order {dp,g,f,e,d,c,b,a}; display bytes run digit 4 (left) down to digit 0
    localparam int          SPD_DP_BIT        = 7;
    localparam int          SPD_VOLT_DP_DIGIT = 2;
    localparam logic [7:0]  SPD_SEG_BLANK     = 8'h00;
    localparam logic [7:0]  SPD_SEG_MINUS     = 8'h40;

    // Identifying symbols, index 15 first
    localparam logic [15:0][39:0] SPD_SYMBOL = {
        40'h0000000077, 40'h000000003E, 40'h000000001C, 40'h0000000071,
        40'h0000000050, 40'h0000397371, 40'h0000F9003F, 40'h003973B83F,
        40'h003973F63F, 40'h007173B83F, 40'h007173F63F, 40'h0000F90006,
        40'h003973B806, 40'h003973F606, 40'h007173B806, 40'h007173F606};

    // Write feedback messages
    localparam logic [39:0] SPD_MSG_DONE_SEG  = 40'h4079545E40;
    localparam logic [39:0] SPD_MSG_BUSY_SEG  = 40'h406D3F5440;
    localparam logic [39:0] SPD_MSG_RANGE_SEG = 40'h403F500040;

    typedef enum logic [3:0] {
        feedback_count_high_pre_scale  = 4'h0,
        feedback_count_low_pre_scale   = 4'h1,
        command_count_high_pre_scale   = 4'h2,
        command_count_low_pre_scale    = 4'h3,
        error_count_pre_scale          = 4'h4,
        feedback_count_high_post_scale = 4'h5,
        feedback_count_low_post_scale  = 4'h6,
        command_count_high_post_scale  = 4'h7,
        command_count_low_post_scale   = 4'h8,
        error_count_post_scale         = 4'h9,
        command_pulse_rate             = 4'hA,
        motor_speed                    = 4'hB,
        speed_analog_voltage           = 4'hC,
        speed_input_setting            = 4'hD,
        torque_analog_voltage          = 4'hE,
        auxiliary_status               = 4'hF
    } spd_item_t;

    localparam spd_item_t   SPD_ITEM_FIRST = feedback_count_high_pre_scale;
    localparam spd_item_t   SPD_ITEM_LAST  = auxiliary_status;

    typedef enum logic [1:0] {
        SPD_CM_POSITION = 2'h0,
        SPD_CM_SPEED    = 2'h1,
        SPD_CM_TORQUE   = 2'h2
    } spd_ctrl_mode_t;

    typedef enum logic [1:0] {
        SPD_MD_SYMBOL  = 2'h0,
        SPD_MD_VALUE   = 2'h1,
        SPD_MD_MESSAGE = 2'h2
    } spd_mode_t;

    typedef enum logic [1:0] {
        SPD_CL_LOW   = 2'h0,
        SPD_CL_HIGH  = 2'h1,
        SPD_CL_PLAIN = 2'h2,
        SPD_CL_VOLT  = 2'h3
    } spd_class_t;

    // Measured quantities; voltages in hundredths of a volt
    typedef struct packed {
        logic signed [31:0] fb_pre;
        logic signed [31:0] cmd_pre;
        logic signed [31:0] fb_post;
        logic signed [31:0] cmd_post;
        logic signed [31:0] err_pre;
        logic signed [31:0] err_post;
        logic signed [31:0] pulse_rate_khz;
        logic signed [31:0] speed_rpm;
        logic signed [31:0] speed_cmd_cv;
        logic signed [31:0] speed_lim_cv;
        logic signed [31:0] speed_cmd_rpm;
        logic signed [31:0] speed_lim_rpm;
        logic signed [31:0] analog_torque_limit_input;
        logic signed [31:0] torque_cmd_cv;
        logic signed [31:0] aux;
    } spd_status_t;

    typedef struct packed {
        logic signed [31:0] value;
        logic signed [31:0] low_limit;
        logic signed [31:0] high_limit;
        logic               hex_radix;
    } spd_param_req_t;

    typedef struct packed {
        logic [4:0][7:0] digit;
    } spd_disp_t;

    function automatic logic [7:0] spd_seg_digit(input logic [3:0] d);
        logic [7:0] s;
        case (d)
            4'h0:    s = 8'h3F;
            4'h1:    s = 8'h06;
            4'h2:    s = 8'h5B;
            4'h3:    s = 8'h4F;
            4'h4:    s = 8'h66;
            4'h5:    s = 8'h6D;
            4'h6:    s = 8'h7D;
            4'h7:    s = 8'h07;
            4'h8:    s = 8'h7F;
            4'h9:    s = 8'h6F;
            default: s = 8'h00;
        endcase
        return s;
    endfunction

endpackage

// >>> design/spd_bcd_conv.sv
// Sequential binary to BCD converter (shift and add-three)
`timescale 1ns/100ps
module spd_bcd_conv
    import spd_pkg::*;
(
    input  wire logic                          clk_i,   // System clock
    input  wire logic                          rst_n_i, // Synchronised reset, active low
    input  wire logic                          start_i, // Begin conversion when idle
    input  wire logic [SPD_BIN_W-1:0]          bin_i,   // Unsigned magnitude
    output logic                               idle_o,  // Ready for start
    output logic                               done_o,  // One-cycle result strobe
    output logic [SPD_BCD_DIGITS*4-1:0]        bcd_o    // Ten BCD digits
);
    logic                          busy_q;
    logic [5:0]                    cnt_q;
    logic [SPD_BIN_W-1:0]          sh_q;
    logic [SPD_BCD_DIGITS*4-1:0]   bcd_q;
    logic [SPD_BCD_DIGITS*4-1:0]   adj;

    // Add three to every digit of five or more before the shift
    always_comb
    begin
        adj = bcd_q;
        for (int i = 0; i < SPD_BCD_DIGITS; i++)
        begin
            if (bcd_q[i*4+:4] > 4'h4)
            begin
                adj[i*4+:4] = bcd_q[i*4+:4] + 4'h3;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            busy_q <= 1'b0;
            cnt_q  <= 6'h00;
            sh_q   <= '0;
            bcd_q  <= '0;
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            if (start_i && !busy_q)
            begin
                busy_q <= 1'b1;
                cnt_q  <= SPD_CONV_STEPS;
                sh_q   <= bin_i;
                bcd_q  <= '0;
            end
            else if (busy_q)
            begin
                bcd_q <= {adj[SPD_BCD_DIGITS*4-2:0], sh_q[SPD_BIN_W-1]};
                sh_q  <= {sh_q[SPD_BIN_W-2:0], 1'b0};
                cnt_q <= cnt_q - 6'h01;
                if (cnt_q == 6'h01)
                begin
                    busy_q <= 1'b0;
                    done_o <= 1'b1;
                end
            end
        end
    end

    assign idle_o = !busy_q;
    assign bcd_o  = bcd_q;
endmodule

// >>> design/spd_status_display.sv
// Front-panel status display formatter with parameter write feedback
`timescale 1ns/100ps
module spd_status_display
    import spd_pkg::*;
#(
    parameter int MSG_CYCLES = SPD_MSG_CYCLES
)
(
    input  wire logic                  clk_sys_i,             // 125 MHz system clock
    input  wire logic                  reset_n_i,             // Asynchronous reset, active low
    input  wire logic                  key_up_i,              // Up key level
    input  wire logic                  key_down_i,            // Down key level
    input  wire logic                  key_set_i,             // Set key level
    input  wire spd_pkg::spd_ctrl_mode_t control_mode_i,      // Drive control mode
    input  wire spd_pkg::spd_status_t  status_i,              // Measured quantities
    input  wire logic                  servo_enable_input_i,  // Servo-on input level
    input  wire logic                  param_wr_req_i,        // Parameter write request pulse
    input  wire spd_pkg::spd_param_req_t param_req_i,         // Write value and limits
    output spd_pkg::spd_disp_t         disp_o,                // Segment patterns
    output spd_pkg::spd_item_t         item_o,                // Selected item
    output spd_pkg::spd_mode_t         mode_o,                // Display mode
    output logic                       param_wr_o,            // Accepted write pulse
    output logic [31:0]                param_data_o           // Accepted write value
);
    import spd_pkg::*;

    logic                  rst_meta_q;
    logic                  rst_n_q;
    logic                  up_q;
    logic                  down_q;
    logic                  set_q;
    logic                  up_press;
    logic                  down_press;
    logic                  set_press;
    logic                  any_press;
    spd_item_t             item_q;
    spd_mode_t             mode_q;
    logic [39:0]           msg_seg_q;
    logic [31:0]           msg_cnt_q;
    logic signed [31:0]    src_val;
    spd_class_t            src_class;
    logic                  src_neg;
    logic [SPD_BIN_W-1:0]  src_mag;
    logic                  conv_idle;
    logic                  conv_done;
    logic [39:0]           conv_bcd;
    logic                  run_neg_q;
    spd_class_t            run_class_q;
    logic                  val_neg_q;
    spd_class_t            val_class_q;
    logic [39:0]           val_bcd_q;
    logic [19:0]           page;
    logic [39:0]           val_seg;
    logic                  range_bad;
    spd_disp_t             disp_d;

    // Reset release through two flip-flops
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // Key edge detection
    always_ff @(posedge clk_sys_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            up_q   <= 1'b0;
            down_q <= 1'b0;
            set_q  <= 1'b0;
        end
        else
        begin
            up_q   <= key_up_i;
            down_q <= key_down_i;
            set_q  <= key_set_i;
        end
    end

    assign up_press   = key_up_i && !up_q;
    assign down_press = key_down_i && !down_q;
    assign set_press  = key_set_i && !set_q;
    assign any_press  = up_press || down_press || set_press;

    always_ff @(posedge clk_sys_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            item_q <= SPD_ITEM_FIRST;
        end
        else if (up_press && !down_press)
        begin
            item_q <= (item_q == SPD_ITEM_LAST) ? SPD_ITEM_FIRST : spd_item_t'(item_q + 4'h1);
        end
        else if (down_press && !up_press)
        begin
            item_q <= (item_q == SPD_ITEM_FIRST) ? SPD_ITEM_LAST : spd_item_t'(item_q - 4'h1);
        end
    end

    // Range check against the parameter's own limits
    always_comb
    begin
        if (param_req_i.hex_radix)
        begin
            range_bad = ($unsigned(param_req_i.value) < $unsigned(param_req_i.low_limit)) ||
                        ($unsigned(param_req_i.value) > $unsigned(param_req_i.high_limit));
        end
        else
        begin
            range_bad = (param_req_i.value < param_req_i.low_limit) ||
                        (param_req_i.value > param_req_i.high_limit);
        end
    end

    // Display mode and write feedback
    always_ff @(posedge clk_sys_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            mode_q       <= SPD_MD_SYMBOL;
            msg_seg_q    <= '0;
            msg_cnt_q    <= 32'h0;
            param_wr_o   <= 1'b0;
            param_data_o <= 32'h0;
        end
        else
        begin
            param_wr_o <= 1'b0;
            if (param_wr_req_i)
            begin
                mode_q    <= SPD_MD_MESSAGE;
                msg_cnt_q <= MSG_CYCLES[31:0];
                if (servo_enable_input_i)
                begin
                    msg_seg_q <= SPD_MSG_BUSY_SEG;
                end
                else if (range_bad)
                begin
                    msg_seg_q <= SPD_MSG_RANGE_SEG;
                end
                else
                begin
                    msg_seg_q    <= SPD_MSG_DONE_SEG;
                    param_wr_o   <= 1'b1;
                    param_data_o <= param_req_i.value;
                end
            end
            else
            begin
                case (mode_q)
                    SPD_MD_SYMBOL:
                    begin
                        if (set_press && !up_press && !down_press)
                        begin
                            mode_q <= SPD_MD_VALUE;
                        end
                    end
                    SPD_MD_VALUE:
                    begin
                        if (up_press || down_press)
                        begin
                            mode_q <= SPD_MD_SYMBOL;
                        end
                    end
                    SPD_MD_MESSAGE:
                    begin
                        if (any_press || msg_cnt_q <= 32'h1)
                        begin
                            mode_q <= SPD_MD_SYMBOL;
                        end
                        msg_cnt_q <= msg_cnt_q - 32'h1;
                    end
                    default:
                    begin
                        mode_q <= SPD_MD_SYMBOL;
                    end
                endcase
            end
        end
    end

    // Source selection per item
    always_comb
    begin
        src_class = SPD_CL_PLAIN;
        case (item_q)
            feedback_count_high_pre_scale:  begin src_val = status_i.fb_pre;   src_class = SPD_CL_HIGH; end
            command_count_high_pre_scale:   begin src_val = status_i.cmd_pre;  src_class = SPD_CL_HIGH; end
            feedback_count_high_post_scale: begin src_val = status_i.fb_post;  src_class = SPD_CL_HIGH; end
            command_count_high_post_scale:  begin src_val = status_i.cmd_post; src_class = SPD_CL_HIGH; end
            feedback_count_low_pre_scale:   begin src_val = status_i.fb_pre;   src_class = SPD_CL_LOW;  end
            command_count_low_pre_scale:    begin src_val = status_i.cmd_pre;  src_class = SPD_CL_LOW;  end
            feedback_count_low_post_scale:  begin src_val = status_i.fb_post;  src_class = SPD_CL_LOW;  end
            command_count_low_post_scale:   begin src_val = status_i.cmd_post; src_class = SPD_CL_LOW;  end
            error_count_pre_scale:          begin src_val = status_i.err_pre;  src_class = SPD_CL_LOW;  end
            error_count_post_scale:         begin src_val = status_i.err_post; src_class = SPD_CL_LOW;  end
            command_pulse_rate:             src_val = status_i.pulse_rate_khz;
            motor_speed:                    src_val = status_i.speed_rpm;
            speed_analog_voltage:
            begin
                src_val   = (control_mode_i == SPD_CM_TORQUE) ? status_i.speed_lim_cv : status_i.speed_cmd_cv;
                src_class = SPD_CL_VOLT;
            end
            speed_input_setting:
            begin
                src_val = (control_mode_i == SPD_CM_TORQUE) ? status_i.speed_lim_rpm : status_i.speed_cmd_rpm;
            end
            torque_analog_voltage:
            begin
                src_class = SPD_CL_VOLT;
                if (control_mode_i == SPD_CM_TORQUE)
                begin
                    src_val = status_i.torque_cmd_cv;
                end
                else
                begin
                    src_val = status_i.analog_torque_limit_input[31] ? 32'sh0 : status_i.analog_torque_limit_input;
                end
            end
            default:                        src_val = status_i.aux;
        endcase
    end

    assign src_neg = src_val[31];
    assign src_mag = src_neg ? (32'h0 - $unsigned(src_val)) : $unsigned(src_val);

    spd_bcd_conv u_bcd_conv (
        .clk_i   (clk_sys_i),
        .rst_n_i (rst_n_q),
        .start_i (conv_idle),
        .bin_i   (src_mag),
        .idle_o  (conv_idle),
        .done_o  (conv_done),
        .bcd_o   (conv_bcd)
    );

    // Continuous refresh of the shown value
    always_ff @(posedge clk_sys_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            run_neg_q   <= 1'b0;
            run_class_q <= SPD_CL_PLAIN;
            val_neg_q   <= 1'b0;
            val_class_q <= SPD_CL_PLAIN;
            val_bcd_q   <= '0;
        end
        else
        begin
            if (conv_idle)
            begin
                run_neg_q   <= src_neg;
                run_class_q <= src_class;
            end
            if (conv_done)
            begin
                val_neg_q   <= run_neg_q;
                val_class_q <= run_class_q;
                val_bcd_q   <= conv_bcd;
            end
        end
    end

    // pick high or low digit page
    assign page = (val_class_q == SPD_CL_HIGH) ? val_bcd_q[39:20] : val_bcd_q[19:0];

    // Digit rendering with blanking and sign
    always_comb
    begin
        logic lead;
        lead    = 1'b1;
        val_seg = '0;
        for (int i = 4; i >= 0; i--)
        begin
            if (page[i*4+:4] != 4'h0 || i == 0 || (val_class_q == SPD_CL_VOLT && i <= SPD_VOLT_DP_DIGIT))
            begin
                lead = 1'b0;
            end
            val_seg[i*8+:8] = lead ? SPD_SEG_BLANK : spd_seg_digit(page[i*4+:4]);
        end
        if (val_class_q == SPD_CL_VOLT)
        begin
            val_seg[SPD_VOLT_DP_DIGIT*8+SPD_DP_BIT] = 1'b1;
        end
        if (val_neg_q)
        begin
            if (page[19:16] != 4'h0)
            begin
                for (int i = 0; i < 5; i++)
                begin
                    val_seg[i*8+SPD_DP_BIT] = 1'b1;
                end
            end
            else
            begin
                val_seg[39:32] = SPD_SEG_MINUS;
            end
        end
    end

    always_comb
    begin
        case (mode_q)
            SPD_MD_SYMBOL:  disp_d.digit = SPD_SYMBOL[item_q];
            // value on up to five digits
            SPD_MD_VALUE:   disp_d.digit = val_seg;
            SPD_MD_MESSAGE: disp_d.digit = msg_seg_q;
            default:        disp_d.digit = '0;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            disp_o <= '0;
            item_o <= SPD_ITEM_FIRST;
            mode_o <= SPD_MD_SYMBOL;
        end
        else
        begin
            disp_o <= disp_d;
            item_o <= item_q;
            mode_o <= mode_q;
        end
    end
endmodule

// >>> test/spd_status_display_asserts.sv
// Concurrent checks on the status display ports
`timescale 1ns/100ps
module spd_status_display_asserts
    import spd_pkg::*;
(
    input wire logic                   clk_sys_i,            // Clock
    input wire logic                   reset_n_i,            // Reset, active low
    input wire logic                   key_up_i,             // Up key
    input wire logic                   key_down_i,           // Down key
    input wire logic                   key_set_i,            // Set key
    input wire logic                   servo_enable_input_i, // Servo on
    input wire logic                   param_wr_req_i,       // Write request
    input wire spd_pkg::spd_param_req_t param_req_i,         // Write data
    input wire spd_pkg::spd_disp_t     disp_o,               // Segments
    input wire spd_pkg::spd_item_t     item_o,               // Item
    input wire spd_pkg::spd_mode_t     mode_o,               // Mode
    input wire logic                   param_wr_o,           // Write pulse
    input wire logic [31:0]            param_data_o          // Written value
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    up_step_a: assert property (
        $rose(key_up_i) && !key_down_i && !param_wr_req_i |-> ##2 4'(item_o - $past(item_o, 1)) == 4'h1
        && mode_o == SPD_MD_SYMBOL && disp_o == SPD_SYMBOL[item_o]) else $error("up key step wrong");
    down_step_a: assert property (
        $rose(key_down_i) && !key_up_i && !param_wr_req_i |-> ##2 4'(item_o - $past(item_o, 1)) == 4'hF)
        else $error("down key step wrong");
    both_keys_a: assert property (
        $rose(key_up_i) && $rose(key_down_i) && !param_wr_req_i |-> ##2 item_o == $past(item_o, 2))
        else $error("both keys stepped");
    set_value_a: assert property (
        $rose(key_set_i) && !key_up_i && !key_down_i && !param_wr_req_i && !$past(param_wr_req_i)
        && mode_o == SPD_MD_SYMBOL |-> ##2 mode_o == SPD_MD_VALUE) else $error("set key did not show value");
    busy_msg_a: assert property (
        param_wr_req_i && servo_enable_input_i |=> !param_wr_o ##1 mode_o == SPD_MD_MESSAGE
        && disp_o == SPD_MSG_BUSY_SEG) else $error("servo on write not refused");
    range_msg_a: assert property (
        param_wr_req_i && !servo_enable_input_i && !param_req_i.hex_radix
        && (param_req_i.value < param_req_i.low_limit || param_req_i.value > param_req_i.high_limit)
        |=> !param_wr_o ##1 disp_o == SPD_MSG_RANGE_SEG) else $error("over range write not rejected");
    accept_wr_a: assert property (
        param_wr_req_i && !servo_enable_input_i && !param_req_i.hex_radix
        && param_req_i.value >= param_req_i.low_limit && param_req_i.value <= param_req_i.high_limit
        |=> param_wr_o && param_data_o == $past(param_req_i.value) ##1 disp_o == SPD_MSG_DONE_SEG)
        else $error("valid write not accepted");
    data_hold_a: assert property (
        !param_wr_o |-> $stable(param_data_o)) else $error("write value changed without write");
endmodule
bind spd_status_display spd_status_display_asserts chk_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .key_up_i(key_up_i), .key_down_i(key_down_i), .key_set_i(key_set_i),
    .servo_enable_input_i(servo_enable_input_i), .param_wr_req_i(param_wr_req_i), .param_req_i(param_req_i),
    .disp_o(disp_o), .item_o(item_o), .mode_o(mode_o), .param_wr_o(param_wr_o), .param_data_o(param_data_o));

// >>> test/spd_operator_model.sv
// Operator at the front panel keys
`timescale 1ns/100ps
module spd_operator_model
(
    input  wire logic clk_i,      // Panel clock
    output logic      key_up_o,   // Up key
    output logic      key_down_o, // Down key
    output logic      key_set_o   // Set key
);
    initial {key_set_o, key_down_o, key_up_o} = 3'h0;

    task automatic press(input logic [2:0] keys);
        @(negedge clk_i);
        {key_set_o, key_down_o, key_up_o} = keys;
        @(negedge clk_i);
        {key_set_o, key_down_o, key_up_o} = 3'h0;
    endtask
endmodule

// >>> test/spd_status_display_tb_top.sv
// Self-checking bench for the status display formatter
`timescale 1ns/100ps
`define SPD_CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module spd_status_display_tb_top;
    import spd_pkg::*;
    logic           clk, rst_n, k_up, k_dn, k_set, servo, wr_req, wr;
    spd_param_req_t req;
    spd_status_t    st;
    spd_disp_t      disp;
    spd_item_t      item;
    spd_mode_t      mode;
    spd_ctrl_mode_t ctl;
    logic [31:0]    data;
    int             num_errors = 0;
    int             tests_run = 0;
    int             cycles = 0;

    spd_operator_model op_u (.clk_i(clk), .key_up_o(k_up), .key_down_o(k_dn), .key_set_o(k_set));
    spd_status_display #(.MSG_CYCLES(20)) dut_u (.clk_sys_i(clk), .reset_n_i(rst_n), .key_up_i(k_up),
        .key_down_i(k_dn), .key_set_i(k_set), .control_mode_i(ctl), .status_i(st),
        .servo_enable_input_i(servo), .param_wr_req_i(wr_req), .param_req_i(req), .disp_o(disp),
        .item_o(item), .mode_o(mode), .param_wr_o(wr), .param_data_o(data));

    initial
    begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    task automatic close_out;
        $display("%0d checks, %0d errors", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            close_out;
        end
    end

    task automatic step(input logic [2:0] k, input logic [3:0] exp);
        op_u.press(k);
        repeat (2) @(negedge clk);
        `SPD_CHK(item, exp)
    endtask

    task automatic show(input logic [3:0] it, input logic [39:0] exp);
        for (int i = 0; i < 16 && item !== it; i++)
            step(3'h1, 4'(item + 4'h1));
        op_u.press(3'h4);
        repeat (80) @(negedge clk);
        `SPD_CHK(mode, SPD_MD_VALUE)
        `SPD_CHK(disp, exp)
    endtask

    task automatic wr_do(input logic sv, hex, input logic [31:0] v, lo, hi, input logic [39:0] exp,
                         input logic pulse);
        @(negedge clk);
        servo = sv;
        req = '{v, lo, hi, hex};
        wr_req = 1'h1;
        @(negedge clk);
        wr_req = 1'h0;
        `SPD_CHK(wr, pulse)
        @(negedge clk);
        `SPD_CHK(disp, exp)
        `SPD_CHK(mode, SPD_MD_MESSAGE)
        if (pulse)
            `SPD_CHK(data, v)
    endtask

    task automatic test_keys;
        `SPD_CHK(disp, SPD_SYMBOL[0])
        step(3'h2, 4'hF);
        step(3'h1, 4'h0);
        step(3'h3, 4'h0);
        step(3'h1, 4'h1);
        step(3'h2, 4'h0);
        $display("test keys done");
    endtask

    task automatic test_values;
        show(4'h0, 40'h40065B4F66);
        show(4'h1, 40'hEDFD87FFEF);
        show(4'h4, 40'h4F666D7D07);
        show(4'hA, 40'h407D3F3F3F);
        show(4'hB, 40'h404F3F3F3F);
        show(4'hC, 40'h4000ED5B4F);
        show(4'hD, 40'h00066D3F3F);
        show(4'hE, 40'h0000BF3F3F);
        ctl = SPD_CM_TORQUE;
        show(4'hE, 40'h4000BF076D);
        show(4'hC, 40'h0006BF3F3F);
        show(4'hD, 40'h40005B3F3F);
        $display("test values done");
    endtask

    task automatic test_writes;
        wr_do(1'h1, 1'h0, 32'h5, 32'h0, 32'hA, SPD_MSG_BUSY_SEG, 1'h0);
        wr_do(1'h0, 1'h0, 32'h5, 32'h0, 32'hA, SPD_MSG_DONE_SEG, 1'h1);
        wr_do(1'h0, 1'h0, 32'hFFFFFFFB, 32'hFFFFFFF6, 32'hA, SPD_MSG_DONE_SEG, 1'h1);
        wr_do(1'h0, 1'h0, 32'hB, 32'h0, 32'hA, SPD_MSG_RANGE_SEG, 1'h0);
        wr_do(1'h0, 1'h1, 32'hFFFFFFFB, 32'h0, 32'h100, SPD_MSG_RANGE_SEG, 1'h0);
        wr_do(1'h0, 1'h0, 32'hA, 32'h0, 32'hA, SPD_MSG_DONE_SEG, 1'h1);
        repeat (30) @(negedge clk);
        `SPD_CHK(mode, SPD_MD_SYMBOL)
        $display("test writes done");
    endtask

    initial
    begin
        rst_n = 1'h0;
        servo = 1'h0;
        wr_req = 1'h0;
        req = '0;
        st = '0;
        st.speed_rpm = -32'sd3000;
        st.fb_pre = -32'sd123456789;
        st.err_pre = 32'sd1234567;
        ctl = SPD_CM_SPEED;
        st.pulse_rate_khz = -32'sd6000;
        st.speed_cmd_cv = -32'sd523;
        st.speed_lim_cv = 32'sd1000;
        st.speed_cmd_rpm = 32'sd1500;
        st.speed_lim_rpm = -32'sd200;
        st.analog_torque_limit_input = -32'sd250;
        st.torque_cmd_cv = -32'sd75;
        repeat (3) @(negedge clk);
        rst_n = 1'h1;
        repeat (3) @(negedge clk);
        test_keys;
        test_values;
        test_writes;
        close_out;
    end
endmodule
